// ### rtl/bpsc_defs.svh
/*
 Constants for the bus pin state controller: space codes,
 byte-lane codes, power modes, reset values and widths.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef BPSC_DEFS_SVH
`define BPSC_DEFS_SVH

// ==========================================
// Access space codes
`define BPSC_SPACE_ONCHIP 2'h0
`define BPSC_SPACE_NORMAL 2'h1
`define BPSC_SPACE_MUX 2'h2
`define BPSC_SPACE_DRAM 2'h3

// ==========================================
// Byte-lane codes for 16-bit space
`define BPSC_LANE_UPPER 2'h1
`define BPSC_LANE_LOWER 2'h2
`define BPSC_LANE_WORD 2'h3

// ==========================================
// Power mode codes
`define BPSC_PWR_RUN 2'h0
`define BPSC_PWR_SLEEP 2'h1
`define BPSC_PWR_STANDBY 2'h2

// ==========================================
// Reset values and widths
`define BPSC_FLOAT_RESET 1'h0
`define BPSC_ADDR_W 22
`define BPSC_GPIO_W 16
`define BPSC_IRQ_W 6
`define BPSC_TIOC_W 8

`endif

// ### rtl/bpsc_pkg.sv
/*
 Types for the bus pin state controller.
 Assumes bpsc_defs.svh is on the include path.
*/
`include "bpsc_defs.svh"

package bpsc_pkg;
    typedef enum logic [1:0] {
        BPSC_ST_IDLE = 2'h0,
        BPSC_ST_ADDR = 2'h1,
        BPSC_ST_DATA = 2'h2
    } bpsc_state_t;
endpackage : bpsc_pkg

// ### rtl/bpsc_pin_ctrl.sv
/*
 Pin state controller for the external bus and peripheral pins.
 Assumes a single 100 MHz clock, synchronous inputs and a bus engine
 upstream that issues one access per request pulse.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bpsc_defs.svh"

module bpsc_pin_ctrl #(
    parameter logic FLASH_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Access request
    input wire logic acc_start,
    input wire logic [1:0] acc_space,
    input wire logic acc_wide,
    input wire logic [1:0] acc_lane,
    input wire logic acc_write,
    input wire logic [1:0] acc_area,
    input wire logic [`BPSC_ADDR_W-1:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    // DRAM controls
    input wire logic ras_down_mode,
    input wire logic refresh_active,
    // Power and configuration
    input wire logic [1:0] power_mode,
    input wire logic standby_pin_float,
    input wire logic programming_mode,
    // Port and timer pin sources
    input wire logic [`BPSC_GPIO_W-1:0] gpio_dir,
    input wire logic [`BPSC_GPIO_W-1:0] gpio_out_val,
    input wire logic [`BPSC_TIOC_W-1:0] tioc_dir,
    input wire logic [`BPSC_TIOC_W-1:0] tioc_out_val,
    // Bus pins
    output logic [`BPSC_ADDR_W-1:0] addr_o,
    output logic addr_oe,
    output logic [15:0] data_o,
    output logic [1:0] data_oe,
    output logic [3:0] area_select_n,
    output logic [3:0] area_select_oe,
    output logic read_strobe_n,
    output logic upper_write_strobe_n,
    output logic lower_write_strobe_n,
    output logic write_strobe_oe,
    output logic row_strobe_n,
    output logic upper_column_strobe_n,
    output logic lower_column_strobe_n,
    output logic transfer_direction,
    output logic dram_ctl_oe,
    output logic address_latch_out,
    output logic address_latch_oe,
    output logic clock_out_oe,
    // Peripheral pins
    output logic external_interrupt_pin_ie,
    output logic [`BPSC_GPIO_W-1:0] gpio_o,
    output logic [`BPSC_GPIO_W-1:0] gpio_oe,
    output logic [`BPSC_TIOC_W-1:0] timer_capture_compare_pin_o,
    output logic [`BPSC_TIOC_W-1:0] timer_capture_compare_pin_oe,
    output logic flash_write_enable_status
);

    // ==========================================
    // Access sequencer
    bpsc_pkg::bpsc_state_t state_reg;
    logic [1:0] space_reg;
    logic wide_reg;
    logic [1:0] lane_reg;
    logic write_reg;
    logic [1:0] area_reg;
    logic [15:0] wdata_reg;
    logic float_reg;
    logic standby;
    logic sleep;
    logic hold_drive;

    assign standby = (power_mode == `BPSC_PWR_STANDBY);
    assign sleep = (power_mode == `BPSC_PWR_SLEEP);
    assign hold_drive = !float_reg;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            float_reg <= `BPSC_FLOAT_RESET;
        end else begin
            float_reg <= standby_pin_float;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= bpsc_pkg::BPSC_ST_IDLE;
            space_reg <= `BPSC_SPACE_ONCHIP;
            wide_reg <= 1'b0;
            lane_reg <= 2'h0;
            write_reg <= 1'b0;
            area_reg <= 2'h0;
            wdata_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                bpsc_pkg::BPSC_ST_IDLE: begin
                    if (acc_start && power_mode == `BPSC_PWR_RUN) begin
                        state_reg <= bpsc_pkg::BPSC_ST_ADDR;
                        space_reg <= acc_space;
                        wide_reg <= acc_wide;
                        lane_reg <= acc_wide ? acc_lane : `BPSC_LANE_LOWER;
                        write_reg <= acc_write;
                        area_reg <= acc_area;
                        wdata_reg <= acc_wdata;
                    end
                end
                bpsc_pkg::BPSC_ST_ADDR: begin
                    state_reg <= bpsc_pkg::BPSC_ST_DATA;
                end
                bpsc_pkg::BPSC_ST_DATA: begin
                    state_reg <= bpsc_pkg::BPSC_ST_IDLE;
                end
                default: begin
                    state_reg <= bpsc_pkg::BPSC_ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Address bus, kept from request
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            addr_o <= '0;
            addr_oe <= 1'b1;
            clock_out_oe <= 1'b1;
        end else begin
            if (state_reg == bpsc_pkg::BPSC_ST_IDLE && acc_start) begin
                addr_o <= acc_addr;
            end
            addr_oe <= !(standby && float_reg);
            clock_out_oe <= !(standby && float_reg);
        end
    end

    // ==========================================
    // Strobes and data lanes
    logic in_cycle;
    logic in_data;
    logic is_ext;
    logic up_lane;
    logic lo_lane;
    assign in_cycle = (state_reg != bpsc_pkg::BPSC_ST_IDLE);
    assign in_data = (state_reg == bpsc_pkg::BPSC_ST_DATA);
    assign is_ext = (space_reg != `BPSC_SPACE_ONCHIP);
    assign up_lane = wide_reg && lane_reg[0];
    assign lo_lane = lane_reg[1];

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            area_select_n <= 4'hF;
            area_select_oe <= 4'h3;
            read_strobe_n <= 1'b1;
            upper_write_strobe_n <= 1'b1;
            lower_write_strobe_n <= 1'b1;
            write_strobe_oe <= 1'b1;
            data_o <= 16'h0000;
            data_oe <= 2'h0;
            address_latch_out <= 1'b0;
            address_latch_oe <= 1'b0;
        end else begin
            area_select_n <= 4'hF;
            read_strobe_n <= 1'b1;
            upper_write_strobe_n <= 1'b1;
            lower_write_strobe_n <= 1'b1;
            data_oe <= 2'h0;
            address_latch_out <= 1'b0;
            area_select_oe <= {4{!standby}};
            write_strobe_oe <= !standby;
            address_latch_oe <= !standby;
            if (in_cycle && is_ext) begin
                if (space_reg == `BPSC_SPACE_NORMAL) begin
                    area_select_n[area_reg] <= (area_reg == 2'h3);
                end else if (space_reg == `BPSC_SPACE_MUX) begin
                    area_select_n[3] <= 1'b0;
                end
                read_strobe_n <= write_reg;
                upper_write_strobe_n <= !(write_reg && up_lane);
                lower_write_strobe_n <= !(write_reg && lo_lane);
                if (space_reg == `BPSC_SPACE_MUX && !in_data) begin
                    address_latch_out <= 1'b1;
                    data_o <= {addr_o[15:0]};
                    data_oe <= {wide_reg, 1'b1};
                end else if (write_reg) begin
                    data_o <= wdata_reg;
                    data_oe <= {up_lane, lo_lane};
                end
            end
        end
    end

    // ==========================================
    // DRAM strobes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            row_strobe_n <= 1'b1;
            upper_column_strobe_n <= 1'b1;
            lower_column_strobe_n <= 1'b1;
            transfer_direction <= 1'b1;
            dram_ctl_oe <= 1'b0;
        end else begin
            dram_ctl_oe <= !(standby && float_reg);
            if (in_cycle && space_reg == `BPSC_SPACE_DRAM) begin
                row_strobe_n <= 1'b0;
                upper_column_strobe_n <= !(in_data && up_lane);
                lower_column_strobe_n <= !(in_data && lo_lane);
                transfer_direction <= !write_reg;
            end else begin
                row_strobe_n <= !(ras_down_mode || refresh_active);
                upper_column_strobe_n <= !refresh_active;
                lower_column_strobe_n <= !refresh_active;
                transfer_direction <= 1'b1;
            end
        end
    end

    // ==========================================
    // Peripheral pins and flash status
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            external_interrupt_pin_ie <= 1'b0;
            gpio_o <= '0;
            gpio_oe <= '0;
            timer_capture_compare_pin_o <= '0;
            timer_capture_compare_pin_oe <= '0;
            flash_write_enable_status <= 1'b0;
        end else begin
            external_interrupt_pin_ie <= !standby;
            flash_write_enable_status <= FLASH_VARIANT ? programming_mode : 1'b1;
            if (standby) begin
                gpio_oe <= gpio_dir & {`BPSC_GPIO_W{hold_drive}};
                timer_capture_compare_pin_oe <= tioc_dir & {`BPSC_TIOC_W{hold_drive}};
            end else begin
                gpio_o <= gpio_out_val;
                gpio_oe <= gpio_dir;
                timer_capture_compare_pin_o <= tioc_out_val;
                timer_capture_compare_pin_oe <= tioc_dir;
            end
        end
    end

    // ==========================================
    // Checks
    sequence s_cyc_start;
        state_reg == bpsc_pkg::BPSC_ST_IDLE && acc_start && power_mode == `BPSC_PWR_RUN;
    endsequence
    sequence s_back_idle;
        ##3 (state_reg == bpsc_pkg::BPSC_ST_IDLE) ##1 (area_select_n == 4'hF && read_strobe_n);
    endsequence

    AST_IDLE_HIGH: assert property (@(posedge ref_clk) disable iff (reset)
        s_cyc_start |-> s_back_idle) else $error("strobes not idle after cycle");
    AST_ONCHIP: assert property (@(posedge ref_clk) disable iff (reset)
        $past(in_cycle && !is_ext) |-> area_select_n == 4'hF && data_oe == 2'h0 && !address_latch_out)
        else $error("on-chip access moved a strobe");
    AST_MUX_CS3: assert property (@(posedge ref_clk) disable iff (reset)
        $past(in_cycle && space_reg == `BPSC_SPACE_MUX) |-> area_select_n == 4'h7)
        else $error("mux select wrong");
    AST_AH_ONLY_MUX: assert property (@(posedge ref_clk) disable iff (reset)
        address_latch_out |-> $past(space_reg) == `BPSC_SPACE_MUX) else $error("latch outside mux");
    AST_READ_STROBE: assert property (@(posedge ref_clk) disable iff (reset)
        $past(in_cycle && is_ext && !write_reg) |-> !read_strobe_n && lower_write_strobe_n)
        else $error("read strobe wrong");
    AST_CAS_REFRESH: assert property (@(posedge ref_clk) disable iff (reset)
        $past(!(in_cycle && space_reg == `BPSC_SPACE_DRAM) && !refresh_active) |-> upper_column_strobe_n)
        else $error("column strobe outside refresh");
    AST_RAS_HELD: assert property (@(posedge ref_clk) disable iff (reset)
        $past(ras_down_mode) |-> !row_strobe_n) else $error("row strobe not held");
    AST_STBY_FLOAT: assert property (@(posedge ref_clk) disable iff (reset)
        $past(standby && float_reg) |-> gpio_oe == '0 && timer_capture_compare_pin_oe == '0)
        else $error("standby float not applied");
    AST_IRQ_STBY: assert property (@(posedge ref_clk) disable iff (reset)
        $past(standby) |-> !external_interrupt_pin_ie) else $error("irq pin active in standby");
    AST_FWE_MASK: assert property (@(posedge ref_clk) disable iff (reset) !$past(reset) |->
        flash_write_enable_status == ($past(programming_mode) || !FLASH_VARIANT)) else $error("fwe wrong");

endmodule : bpsc_pin_ctrl
`default_nettype wire

// ### testbench/bpsc_ext_model.sv
/*
 Far-side model of the external bus: counts bus cycles that select a device.
 Assumes registered, active-low selects from the pin controller on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module bpsc_ext_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Bus pins
    input wire logic [3:0] area_select_n,
    // Observation
    output logic [7:0] sel_cnt
);
    logic [3:0] sel_q;

    // ==========================================
    // Select edge counter
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sel_q <= 4'hF;
            sel_cnt <= 8'h00;
        end else begin
            sel_q <= area_select_n;
            if ((&sel_q) && !(&area_select_n)) begin
                sel_cnt <= sel_cnt + 8'h01;
            end
        end
    end
endmodule : bpsc_ext_model

`default_nettype wire

// ### testbench/tb_bpsc_pin_ctrl.sv
/*
 Self-checking bench for the bus pin state controller.
 Assumes the design files and bpsc_defs.svh are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bpsc_defs.svh"

module tb_bpsc_pin_ctrl;
    logic ref_clk = 1'b0, reset = 1'b1, acc_start = 1'b0, acc_wide = 1'b0, acc_write = 1'b0;
    logic [1:0] acc_space = 2'h0, acc_lane = 2'h0, acc_area = 2'h0, power_mode = 2'h0;
    logic [`BPSC_ADDR_W-1:0] acc_addr = '0, addr_o;
    logic [15:0] acc_wdata = 16'h0000, data_o, gpio_dir = 16'h0000, gpio_out_val = 16'h0000, gpio_o, gpio_oe;
    logic ras_down_mode = 1'b0, refresh_active = 1'b0, standby_pin_float = 1'b0, programming_mode = 1'b0;
    logic [7:0] tioc_dir = 8'h00, tioc_out_val = 8'h00, tioc_o, tioc_oe, sel_cnt;
    logic [1:0] data_oe;
    logic [3:0] area_select_n, area_select_oe;
    logic addr_oe, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n;
    logic write_strobe_oe, row_strobe_n, upper_column_strobe_n, lower_column_strobe_n;
    logic transfer_direction, dram_ctl_oe, address_latch_out, address_latch_oe, clock_out_oe;
    logic external_interrupt_pin_ie, flash_write_enable_status;
    logic [3:0] sel_acc;
    logic rd_acc, wu_acc, wl_acc, cu_acc, cl_acc, lat_acc, dir_seen, got;
    logic [1:0] oe_acc;
    logic [15:0] dfirst, dlast;
    int error_cnt = 0, samples_checked = 0;

    bpsc_pin_ctrl #(.FLASH_VARIANT(1'b1)) bpsc_pin_ctrl_inst (.ref_clk(ref_clk), .reset(reset),
        .acc_start(acc_start), .acc_space(acc_space), .acc_wide(acc_wide), .acc_lane(acc_lane),
        .acc_write(acc_write), .acc_area(acc_area), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .ras_down_mode(ras_down_mode), .refresh_active(refresh_active), .power_mode(power_mode),
        .standby_pin_float(standby_pin_float), .programming_mode(programming_mode), .gpio_dir(gpio_dir),
        .gpio_out_val(gpio_out_val), .tioc_dir(tioc_dir), .tioc_out_val(tioc_out_val), .addr_o(addr_o),
        .addr_oe(addr_oe), .data_o(data_o), .data_oe(data_oe), .area_select_n(area_select_n),
        .area_select_oe(area_select_oe), .read_strobe_n(read_strobe_n),
        .upper_write_strobe_n(upper_write_strobe_n), .lower_write_strobe_n(lower_write_strobe_n),
        .write_strobe_oe(write_strobe_oe), .row_strobe_n(row_strobe_n),
        .upper_column_strobe_n(upper_column_strobe_n), .lower_column_strobe_n(lower_column_strobe_n),
        .transfer_direction(transfer_direction), .dram_ctl_oe(dram_ctl_oe),
        .address_latch_out(address_latch_out), .address_latch_oe(address_latch_oe), .clock_out_oe(clock_out_oe),
        .external_interrupt_pin_ie(external_interrupt_pin_ie), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
        .timer_capture_compare_pin_o(tioc_o), .timer_capture_compare_pin_oe(tioc_oe),
        .flash_write_enable_status(flash_write_enable_status));
    bpsc_ext_model bpsc_ext_model_inst (.ref_clk(ref_clk), .reset(reset), .area_select_n(area_select_n),
        .sel_cnt(sel_cnt));

    // ==========================================
    // Clock, reset and watchdog
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #20000;
        error_cnt++;
        stop_test();
    end

    // ==========================================
    // Helpers
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_cyc

    task acc(input logic [1:0] sp, input logic wd, input logic [1:0] ln, input logic wr,
             input logic [1:0] ar, input logic [21:0] ad, input logic [15:0] dt);
        @(posedge ref_clk);
        #1;
        {acc_space, acc_wide, acc_lane, acc_write, acc_area, acc_addr, acc_wdata} = {sp, wd, ln, wr, ar, ad, dt};
        acc_start = 1'b1;
        wait_cyc(1);
        acc_start = 1'b0;
        {sel_acc, rd_acc, wu_acc, wl_acc, cu_acc, cl_acc, lat_acc, oe_acc, got} = 13'h1FF0;
        repeat (5) begin
            wait_cyc(1);
            sel_acc &= area_select_n;
            rd_acc &= read_strobe_n;
            wu_acc &= upper_write_strobe_n;
            wl_acc &= lower_write_strobe_n;
            cu_acc &= upper_column_strobe_n;
            cl_acc &= lower_column_strobe_n;
            lat_acc |= address_latch_out;
            oe_acc |= data_oe;
            if (!row_strobe_n) dir_seen = transfer_direction;
            if (data_oe != 2'h0) begin
                if (!got) dfirst = data_o;
                got = 1'b1;
                dlast = data_o;
            end
        end
        chk("idle", 7'h7F, {area_select_n, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n});
    endtask : acc

    // ==========================================
    // Scenarios
    task t_reset;
        chk("rst_oe", 5'h1C, {addr_oe, clock_out_oe, write_strobe_oe, data_oe});
        chk("rst_stb", 4'hE, {read_strobe_n, upper_write_strobe_n, lower_write_strobe_n, external_interrupt_pin_ie});
        chk("rst_cs", 10'h3CC, {area_select_n, area_select_oe, dram_ctl_oe, address_latch_oe});
        chk("rst_irq", 1'b0, external_interrupt_pin_ie);
        chk("rst_tioc", 8'h00, tioc_oe);
        $display("test reset done");
    endtask : t_reset

    task t_onchip;
        acc(`BPSC_SPACE_ONCHIP, 1'b1, `BPSC_LANE_WORD, 1'b1, 2'h1, 22'h2ABCDE, 16'h1357);
        chk("oc_stb", 12'hFF8, {sel_acc, rd_acc, wu_acc, wl_acc, cu_acc, cl_acc, lat_acc, oe_acc});
        chk("oc_addr", 22'h2ABCDE, addr_o);
        $display("test onchip done");
    endtask : t_onchip

    task t_normal;
        logic up, lo;
        for (int a = 0; a < 3; a++) begin
            for (int k = 0; k < 4; k++) begin
                acc(`BPSC_SPACE_NORMAL, k != 0, k[1:0], 1'b1, a[1:0], 22'h001000, 16'hC3A5);
                up = (k == 1) || (k == 3);
                lo = (k != 1);
                chk("nm_sel", 4'hF ^ (4'h1 << a), sel_acc);
                chk("nm_wstb", {1'b1, ~up, ~lo}, {rd_acc, wu_acc, wl_acc});
                chk("nm_lane", {up, lo}, oe_acc);
                chk("nm_data", 16'hC3A5 & {{8{up}}, {8{lo}}}, dlast & {{8{up}}, {8{lo}}});
            end
        end
        acc(`BPSC_SPACE_NORMAL, 1'b1, `BPSC_LANE_WORD, 1'b0, 2'h2, 22'h000200, 16'h0000);
        chk("nm_rd", 5'h0C, {sel_acc[2], rd_acc, wu_acc, wl_acc, oe_acc});
        $display("test normal done");
    endtask : t_normal

    task t_mux;
        acc(`BPSC_SPACE_MUX, 1'b1, `BPSC_LANE_WORD, 1'b1, 2'h0, 22'h001234, 16'hBEEF);
        chk("mx_sel", 4'h7, sel_acc);
        chk("mx_lat", 1'b1, lat_acc);
        chk("mx_ad", 32'h1234BEEF, {dfirst, dlast});
        acc(`BPSC_SPACE_MUX, 1'b0, `BPSC_LANE_LOWER, 1'b1, 2'h0, 22'h000056, 16'h0077);
        chk("mx_8", 3'h5, {lat_acc, oe_acc});
        $display("test mux done");
    endtask : t_mux

    task t_dram;
        for (int k = 1; k < 4; k++) begin
            acc(`BPSC_SPACE_DRAM, 1'b1, k[1:0], k[1], 2'h0, 22'h003000, 16'h4321);
            chk("dr_sel", 5'h1E, {sel_acc, lat_acc});
            chk("dr_cas", {k[0] == 1'b0, k[1] == 1'b0}, {cu_acc, cl_acc});
            chk("dr_dir", k[1] == 1'b0, dir_seen);
        end
        ras_down_mode = 1'b1;
        wait_cyc(3);
        chk("rasdn", 3'h3, {row_strobe_n, upper_column_strobe_n, lower_column_strobe_n});
        ras_down_mode = 1'b0;
        refresh_active = 1'b1;
        wait_cyc(3);
        chk("refr", 3'h0, {row_strobe_n, upper_column_strobe_n, lower_column_strobe_n});
        refresh_active = 1'b0;
        wait_cyc(3);
        chk("norefr", 3'h7, {row_strobe_n, upper_column_strobe_n, lower_column_strobe_n});
        $display("test dram done");
    endtask : t_dram

    task t_power;
        {gpio_dir, gpio_out_val, tioc_dir, tioc_out_val} = 48'h00FF_5A5A_0F_3C;
        wait_cyc(3);
        power_mode = `BPSC_PWR_STANDBY;
        gpio_out_val = 16'h0000;
        wait_cyc(3);
        chk("sb_gpio", 32'h00FF005A, {gpio_oe, gpio_o & gpio_oe});
        chk("sb_tioc", 16'h0F0C, {tioc_oe, tioc_o & tioc_oe});
        chk("sb_irq", 2'h2, {addr_oe, external_interrupt_pin_ie});
        chk("sb_oe", 8'hC0, {clock_out_oe, dram_ctl_oe, area_select_oe, write_strobe_oe, address_latch_oe});
        standby_pin_float = 1'b1;
        wait_cyc(3);
        chk("sb_flt", 25'h0, {gpio_oe, tioc_oe, addr_oe});
        chk("sb_flt_oe", 8'h00, {clock_out_oe, dram_ctl_oe, area_select_oe, write_strobe_oe, address_latch_oe});
        standby_pin_float = 1'b0;
        power_mode = `BPSC_PWR_SLEEP;
        wait_cyc(3);
        chk("sl_pins", 9'h10F, {external_interrupt_pin_ie, tioc_oe});
        power_mode = `BPSC_PWR_RUN;
        programming_mode = 1'b1;
        wait_cyc(3);
        chk("fwe_prog", 1'b1, flash_write_enable_status);
        programming_mode = 1'b0;
        wait_cyc(3);
        chk("fwe_app", 1'b0, flash_write_enable_status);
        chk("ext_cnt", 8'h0F, sel_cnt);
        $display("test power done");
    endtask : t_power

    // ==========================================
    // Sequence and verdict
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        wait_cyc(4);
        t_reset();
        wait_cyc(4);
        reset = 1'b0;
        t_onchip();
        t_normal();
        t_mux();
        t_dram();
        t_power();
        stop_test();
    end
endmodule : tb_bpsc_pin_ctrl

`default_nettype wire
